// ---- rtl/lpi_pkg.sv ----
// Purpose: shared constants and types for the lcd power/indicator command decoder
// Assumes: command bytes arrive as one-cycle strobes on the system clock
// Notes:   codes below are the command byte encodings
package lpi_pkg;

    // ****************************************
    // command encodings
    // ****************************************
    localparam logic [4:0] RATIO_PREFIX   = 5'h04;
    localparam logic [7:0] VOLUME_MODE    = 8'h81;
    localparam logic [6:0] INDICATOR_PFX  = 7'h56;
    localparam logic [7:0] NO_OP          = 8'hE3;
    localparam logic [7:0] SOFT_RESET     = 8'hE2;
    localparam logic [7:0] RMW_ENTER      = 8'hE0;
    localparam logic [7:0] RMW_END        = 8'hEE;
    localparam logic [3:0] TEST_PFX       = 4'hF;
    localparam logic [6:0] DISPLAY_ONOFF  = 7'h57;
    localparam logic [6:0] ALL_POINTS     = 7'h52;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] RATIO_RESET    = 3'h0;
    localparam logic [5:0] VOLUME_RESET   = 6'h00;
    localparam logic [1:0] IND_RESET      = 2'h0;
    localparam int         VOLUME_LEVELS  = 64;

    // ****************************************
    // blink timing
    // ****************************************
    localparam int         CLK_MHZ        = 200;
    localparam int         SLOW_MS        = 1000;
    localparam int         FAST_MS        = 500;
    localparam int         SLOW_CYCLES    = SLOW_MS * 1000 * CLK_MHZ;
    localparam int         FAST_CYCLES    = FAST_MS * 1000 * CLK_MHZ;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        IND_OFF, IND_BLINK_SLOW, IND_BLINK_FAST, IND_STEADY
    } lpi_ind_e;

    typedef struct packed {
        logic       dc;
        logic [7:0] data;
    } lpi_byte_s;

    typedef struct packed {
        logic osc_run;
        logic supply_run;
        logic duty_drive_run;
        logic static_run;
        logic outputs_at_vdd;
    } lpi_power_s;

endpackage : lpi_pkg

// ---- rtl/lpi_sync.sv ----
// Purpose: two-flop synchroniser for pin-level inputs
// Assumes: single clock domain on the far side
// Notes:   first stage is read only by the second
module lpi_sync #(
    parameter int WIDTH = 1
) (
    // clocking
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : lpi_sync

// ---- rtl/lpi_blink.sv ----
// Purpose: indicator blink generator for the static indicator pin
// Assumes: periods given in sys_clk cycles
// Notes:   counters freeze with the clock enable
module lpi_blink #(
    parameter int SLOW_PERIOD = lpi_pkg::SLOW_CYCLES,
    parameter int FAST_PERIOD = lpi_pkg::FAST_CYCLES
) (
    // clocking
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // control
    input  wire logic       run,
    input  wire logic [1:0] mode,
    output logic            lit
);
    // below two cycles a half period would round to zero and the pin would toggle every cycle
    if (SLOW_PERIOD < 2 || FAST_PERIOD < 2) begin : g_bad_period
        $error("blink periods must be at least two cycles");
    end

    logic [31:0] cnt_q;
    logic        phase_q;
    logic [31:0] limit;

    assign limit = (mode == 2'(lpi_pkg::IND_BLINK_FAST)) ? 32'(FAST_PERIOD / 2)
                                                        : 32'(SLOW_PERIOD / 2);

    // ****************************************
    // half-period counter
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q   <= 32'h0000_0000;
            phase_q <= 1'b1;
        end else if (clk_en) begin
            if (!run) begin
                cnt_q   <= 32'h0000_0000;
                phase_q <= 1'b1;
            end else if (cnt_q + 32'h0000_0001 >= limit) begin
                cnt_q   <= 32'h0000_0000;
                phase_q <= ~phase_q;
            end else begin
                cnt_q <= cnt_q + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // output
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lit <= 1'b0;
        end else if (clk_en) begin
            case (mode)
                2'(lpi_pkg::IND_OFF):    lit <= 1'b0;
                2'(lpi_pkg::IND_STEADY): lit <= run;
                default:                 lit <= run & phase_q;
            endcase
        end
    end

endmodule : lpi_blink

// ---- rtl/lpi_cmd.sv ----
// Purpose: command decoder for regulator ratio, volume, indicator and power save
// Assumes: cmd_valid is a one-cycle strobe from logic on sys_clk
// Notes:   hw_reset_pin is a pin and is synchronised before use
module lpi_cmd #(
    parameter int SLOW_PERIOD = lpi_pkg::SLOW_CYCLES,
    parameter int FAST_PERIOD = lpi_pkg::FAST_CYCLES
) (
    // clocking
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // host byte strobe
    input  wire logic                cmd_valid,
    input  wire lpi_pkg::lpi_byte_s  cmd_in,
    // pins
    input  wire logic                hw_reset_pin_n,
    output logic                     display_blank_out_n,
    output logic                     indicator_drive_pin,
    // settings
    output logic [2:0]               regulator_resistor_ratio,
    output logic [5:0]               volume_level,
    output logic [1:0]               indicator_state,
    output logic                     display_on,
    output logic                     all_points_on,
    output logic                     rmw_mode,
    output logic                     test_mode,
    // power state
    output logic                     sleep_mode,
    output logic                     standby_mode,
    output lpi_pkg::lpi_power_s      power
);
    typedef enum logic [1:0] {
        ST_IDLE, ST_VOL_DATA, ST_IND_DATA
    } lpi_dec_e;

    lpi_dec_e   state_q;
    logic       pin_rst;
    logic       zap;
    logic       cmd;
    logic [7:0] b;
    logic       is_soft_rst;
    logic       power_save;

    // ****************************************
    // pin reset synchroniser
    // ****************************************
    lpi_sync #(.WIDTH(1)) u_rst_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (~hw_reset_pin_n),
        .sync_out (pin_rst)
    );

    assign zap         = rst | pin_rst;
    assign cmd         = cmd_valid & ~cmd_in.dc;
    assign b           = cmd_in.data;
    assign is_soft_rst = cmd & (state_q == ST_IDLE) & (b == lpi_pkg::SOFT_RESET);

    // ****************************************
    // multi-byte sequencer
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (zap) begin
            state_q <= ST_IDLE;
        end else if (clk_en && cmd) begin
            case (state_q)
                ST_IDLE: begin
                    if (b == lpi_pkg::VOLUME_MODE) begin
                        state_q <= ST_VOL_DATA;
                    end else if (b == {lpi_pkg::INDICATOR_PFX, 1'b1}) begin
                        state_q <= ST_IND_DATA;
                    end
                end
                ST_VOL_DATA: state_q <= ST_IDLE;
                ST_IND_DATA: state_q <= ST_IDLE;
                default:     state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // regulator ratio and volume
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (zap) begin
            regulator_resistor_ratio <= lpi_pkg::RATIO_RESET;
            volume_level             <= lpi_pkg::VOLUME_RESET;
        end else if (clk_en && cmd) begin
            if (state_q == ST_VOL_DATA) begin
                volume_level <= b[5:0];
            end else if (state_q == ST_IDLE) begin
                if (b[7:3] == lpi_pkg::RATIO_PREFIX) begin
                    regulator_resistor_ratio <= b[2:0];
                end else if (b == lpi_pkg::SOFT_RESET) begin
                    regulator_resistor_ratio <= lpi_pkg::RATIO_RESET;
                    volume_level             <= lpi_pkg::VOLUME_RESET;
                end
            end
        end
    end

    // ****************************************
    // static indicator
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (zap) begin
            indicator_state <= lpi_pkg::IND_RESET;
        end else if (clk_en && cmd) begin
            // only the indicator bytes and reset touch this
            if (state_q == ST_IND_DATA) begin
                indicator_state <= b[1:0];
            end else if (state_q == ST_IDLE) begin
                if (b == {lpi_pkg::INDICATOR_PFX, 1'b0}) begin
                    indicator_state <= lpi_pkg::IND_RESET;
                end else if (b == lpi_pkg::SOFT_RESET) begin
                    indicator_state <= lpi_pkg::IND_RESET;
                end
            end
        end
    end

    // ****************************************
    // display flags, rmw and test
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (zap) begin
            display_on    <= 1'b0;
            all_points_on <= 1'b0;
            rmw_mode      <= 1'b0;
            test_mode     <= 1'b0;
        end else if (clk_en && cmd && state_q == ST_IDLE) begin
            if (b[7:1] == lpi_pkg::DISPLAY_ONOFF) begin
                display_on <= b[0];
            end else if (b[7:1] == lpi_pkg::ALL_POINTS) begin
                all_points_on <= b[0];
            end else if (b == lpi_pkg::RMW_ENTER) begin
                rmw_mode <= 1'b1;
            end else if (b == lpi_pkg::RMW_END) begin
                rmw_mode <= 1'b0;
            end else if (b == lpi_pkg::SOFT_RESET) begin
                rmw_mode  <= 1'b0;
                test_mode <= 1'b0;
            end else if (b == lpi_pkg::NO_OP) begin
                test_mode <= 1'b0;
            end else if (b[7:4] == lpi_pkg::TEST_PFX) begin
                test_mode <= 1'b1;
            end
        end
    end

    // ****************************************
    // power save
    // ****************************************
    // settings registers are never cleared here, so state survives power save
    assign power_save = all_points_on & ~display_on;

    always_ff @(posedge sys_clk) begin
        if (zap) begin
            sleep_mode   <= 1'b0;
            standby_mode <= 1'b0;
        end else if (clk_en) begin
            if (!power_save) begin
                sleep_mode   <= 1'b0;
                standby_mode <= 1'b0;
            end else if (!sleep_mode && !standby_mode) begin
                // indicator decides sleep or standby at entry
                sleep_mode   <= (indicator_state == lpi_pkg::IND_RESET);
                standby_mode <= (indicator_state != lpi_pkg::IND_RESET);
            end else if (standby_mode && is_soft_rst) begin
                standby_mode <= 1'b0;
                sleep_mode   <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (zap) begin
            display_blank_out_n <= 1'b1;
        end else if (clk_en) begin
            display_blank_out_n <= ~(sleep_mode | standby_mode);
        end
    end

    // sleep stops everything; standby keeps oscillator and static drive
    always_comb begin
        power.osc_run        = ~sleep_mode;
        power.supply_run     = ~(sleep_mode | standby_mode);
        power.duty_drive_run = ~(sleep_mode | standby_mode);
        power.static_run     = ~sleep_mode;
        power.outputs_at_vdd = sleep_mode | standby_mode;
    end

    // ****************************************
    // indicator pin drive
    // ****************************************
    lpi_blink #(
        .SLOW_PERIOD (SLOW_PERIOD),
        .FAST_PERIOD (FAST_PERIOD)
    ) u_blink (
        .sys_clk (sys_clk),
        .rst     (zap),
        .clk_en  (clk_en),
        .run     (~sleep_mode),
        .mode    (indicator_state),
        .lit     (indicator_drive_pin)
    );

endmodule : lpi_cmd

// ---- tb/lpi_cmd_asserts.sv ----
// Purpose: port checks on the lpi command decoder
// Assumes: one clock, rst synchronous active high
// Notes:   pending flags rebuilt here from the byte stream
module lpi_cmd_asserts #(
    parameter int SLOW_PERIOD = lpi_pkg::SLOW_CYCLES,
    parameter int FAST_PERIOD = lpi_pkg::FAST_CYCLES
) (
    // clocking and strobe
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               clk_en,
    input wire logic               cmd_valid,
    input wire lpi_pkg::lpi_byte_s cmd_in,
    input wire logic               hw_reset_pin_n,
    // results
    input wire logic               display_blank_out_n,
    input wire logic [2:0]         regulator_resistor_ratio,
    input wire logic [5:0]         volume_level,
    input wire logic [1:0]         indicator_state,
    input wire logic               display_on,
    input wire logic               all_points_on,
    input wire logic               sleep_mode,
    input wire logic               standby_mode,
    input wire lpi_pkg::lpi_power_s power
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic       tk;
    logic       free;
    logic       vp_q;
    logic       ip_q;
    logic [3:0] pin_q;
    assign tk   = clk_en && cmd_valid && !cmd_in.dc;
    assign free = tk && !vp_q && !ip_q;
    // pin history: synchroniser lag hides a few edges after the pin moves
    always_ff @(posedge sys_clk) begin
        pin_q <= {pin_q[2:0], hw_reset_pin_n};
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !pin_q[1]) begin
            vp_q <= 1'b0;
            ip_q <= 1'b0;
        end else if (tk) begin
            vp_q <= free && cmd_in.data == lpi_pkg::VOLUME_MODE;
            ip_q <= free && cmd_in.data == {lpi_pkg::INDICATOR_PFX, 1'b1};
        end
    end
    property p_ratio;
        free && cmd_in.data[7:3] == lpi_pkg::RATIO_PREFIX
        |=> regulator_resistor_ratio == $past(cmd_in.data[2:0]);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio not loaded");
    property p_vol;
        tk && vp_q |=> volume_level == $past(cmd_in.data[5:0]);
    endproperty
    a_vol: assert property (p_vol) else $error("volume not loaded");
    property p_ind_off;
        free && cmd_in.data == {lpi_pkg::INDICATOR_PFX, 1'b0} |=> indicator_state == 2'h0;
    endproperty
    a_ind_off: assert property (p_ind_off) else $error("indicator not off");
    property p_ind;
        tk && ip_q |=> indicator_state == $past(cmd_in.data[1:0]);
    endproperty
    a_ind: assert property (p_ind) else $error("indicator data not loaded");
    property p_ind_hold;
        &pin_q && !(tk && (ip_q || (!vp_q && (cmd_in.data[7:1] == lpi_pkg::INDICATOR_PFX
        || cmd_in.data == lpi_pkg::SOFT_RESET)))) |=> $stable(indicator_state);
    endproperty
    a_ind_hold: assert property (p_ind_hold) else $error("indicator moved");
    property p_psave;
        $rose(all_points_on) && !display_on
        |=> sleep_mode != standby_mode && standby_mode == ($past(indicator_state) != 2'h0);
    endproperty
    a_psave: assert property (p_psave) else $error("wrong power save mode");
    property p_blank_lo;
        &pin_q && (sleep_mode || standby_mode) |=> !display_blank_out_n;
    endproperty
    a_blank_lo: assert property (p_blank_lo) else $error("blank output high");
    property p_blank_hi;
        !(sleep_mode || standby_mode) [*2] |-> display_blank_out_n;
    endproperty
    a_blank_hi: assert property (p_blank_hi) else $error("blank output low");
    property p_stby_rst;
        free && standby_mode && cmd_in.data == lpi_pkg::SOFT_RESET
        |-> ##[1:2] sleep_mode && !standby_mode;
    endproperty
    a_stby_rst: assert property (p_stby_rst) else $error("standby not to sleep");
    property p_sleep_pwr;
        sleep_mode |-> !power.osc_run && !power.supply_run && !power.duty_drive_run
        && power.outputs_at_vdd;
    endproperty
    a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep power wrong");
    property p_stby_pwr;
        standby_mode |-> power.osc_run && !power.supply_run && !power.duty_drive_run
        && power.outputs_at_vdd;
    endproperty
    a_stby_pwr: assert property (p_stby_pwr) else $error("standby power wrong");
endmodule : lpi_cmd_asserts

bind lpi_cmd lpi_cmd_asserts #(.SLOW_PERIOD(SLOW_PERIOD), .FAST_PERIOD(FAST_PERIOD)) u_chk (
    .sys_clk, .rst, .clk_en, .cmd_valid, .cmd_in, .hw_reset_pin_n, .display_blank_out_n,
    .regulator_resistor_ratio, .volume_level, .indicator_state, .display_on,
    .all_points_on, .sleep_mode, .standby_mode, .power
);

// ---- tb/lpi_host.sv ----
// Purpose: host processor model writing command bytes
// Assumes: tasks called from the bench's main process
// Notes:   released byte lines show the inverse, never the last byte
module lpi_host (
    // clocking
    input  wire logic          sys_clk,
    // byte strobe
    output logic               cmd_valid,
    output lpi_pkg::lpi_byte_s cmd_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_in    = '0;
    end
    task automatic put(input logic dc, input logic [7:0] b);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_in    = '{dc: dc, data: b};
        @(negedge sys_clk);
        cmd_valid   = 1'b0;
        cmd_in.data = ~b;
    endtask : put
    // two-byte commands go back to back, data straight after its mode byte
    task automatic pair(input logic [7:0] a, input logic [7:0] b);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_in    = '{dc: 1'b0, data: a};
        @(negedge sys_clk);
        cmd_in.data = b;
        @(negedge sys_clk);
        cmd_valid   = 1'b0;
        cmd_in.data = ~b;
    endtask : pair
endmodule : lpi_host

// ---- tb/test_lpi_cmd.sv ----
// Purpose: self-checking bench for the lpi command decoder
// Assumes: blink periods shortened to keep the run short
// Notes:   inputs move on the falling edge only
module test_lpi_cmd;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, clk_en, cmd_valid, hw_reset_pin_n, display_blank_out_n;
    logic indicator_drive_pin, display_on, all_points_on, rmw_mode, test_mode;
    logic sleep_mode, standby_mode;
    logic [2:0]          regulator_resistor_ratio;
    logic [5:0]          volume_level;
    logic [1:0]          indicator_state;
    logic [7:0]          r;
    lpi_pkg::lpi_byte_s  cmd_in;
    lpi_pkg::lpi_power_s power;
    int n_errors, check_count, seed, i, hits;
    lpi_cmd #(.SLOW_PERIOD(20), .FAST_PERIOD(10)) DUT (.sys_clk, .rst, .clk_en, .cmd_valid,
        .cmd_in, .hw_reset_pin_n, .display_blank_out_n, .indicator_drive_pin,
        .regulator_resistor_ratio, .volume_level, .indicator_state, .display_on,
        .all_points_on, .rmw_mode, .test_mode, .sleep_mode, .standby_mode, .power);
    lpi_host host (.sys_clk, .cmd_valid, .cmd_in);
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    function automatic logic [7:0] f_low(input logic [7:0] b, input int w);
        return b & ~(8'hFF << w);
    endfunction : f_low
    // lit cycles in a 20-cycle window: blink modes are lit half the time
    function automatic logic [7:0] f_lit(input logic [1:0] k);
        return (k == 2'h0) ? 8'h00 : ((k == 2'h3) ? 8'h14 : 8'h0A);
    endfunction : f_lit
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle
    task automatic close_out;
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // indicator set, display off, all points on: settles within three edges
    task automatic enter(input logic [1:0] k);
        if (k == 2'h0) host.put(1'b0, 8'hAC);
        else host.pair(8'hAD, {6'h3F, k});
        host.put(1'b0, 8'hAE);
        host.put(1'b0, 8'hA5);
        idle(4);
        chk("sleep", {7'h00, k == 2'h0}, {7'h00, sleep_mode});
        chk("standby", {7'h00, k != 2'h0}, {7'h00, standby_mode});
        chk("blank", 8'h00, {7'h00, display_blank_out_n});
        chk("ratio", 8'h03, {5'h00, regulator_resistor_ratio});
        chk("volume", 8'h20, {2'h0, volume_level});
        chk("display", 8'h02, {6'h00, all_points_on, display_on});
        chk("power", (k == 2'h0) ? 8'h01 : 8'h13, {3'h0, power});
    endtask : enter
    task automatic leave;
        host.put(1'b0, 8'hA4);
        idle(4);
        chk("blank", 8'h01, {7'h00, display_blank_out_n});
        chk("modes", 8'h00, {6'h00, sleep_mode, standby_mode});
        chk("all_points", 8'h00, {7'h00, all_points_on});
        chk("power", 8'h1E, {3'h0, power});
    endtask : leave
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
    initial begin
        seed = 12;
        n_errors = 0;
        check_count = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        hw_reset_pin_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        for (i = 0; i < 8; i++) begin
            host.put(1'b0, 8'h20 | 8'(i));
            chk("ratio", f_low(8'(i), 3), {5'h00, regulator_resistor_ratio});
        end
        // volume data that looks like a command must still load as data
        for (i = 0; i < 6; i++) begin
            r = (i == 0) ? 8'hE2 : 8'($random(seed));
            host.pair(8'h81, r);
            host.put(1'b0, 8'h23);
            chk("volume", f_low(r, 6), {2'h0, volume_level});
            chk("ratio", 8'h03, {5'h00, regulator_resistor_ratio});
        end
        host.pair(8'h81, 8'h20);
        host.put(1'b1, 8'h27);
        clk_en = 1'b0;
        host.put(1'b0, 8'h26);
        clk_en = 1'b1;
        chk("ratio", 8'h03, {5'h00, regulator_resistor_ratio});
        for (i = 0; i < 4; i++) begin
            r = 8'($random(seed));
            r[1:0] = 2'(i);
            host.pair(8'hAD, r);
            host.put(1'b0, 8'hAF);
            host.put(1'b0, 8'hA6);
            chk("indicator", f_low(r, 2), {6'h00, indicator_state});
            // let a mode change settle before counting lit cycles
            idle(8);
            hits = 0;
            repeat (20) begin
                @(negedge sys_clk);
                if (indicator_drive_pin !== 1'b0) hits++;
            end
            chk("ind_blink", f_lit(2'(i)), 8'(hits));
        end
        chk("ind_pin", 8'h01, {7'h00, indicator_drive_pin});
        host.put(1'b0, 8'hAC);
        chk("indicator", 8'h00, {6'h00, indicator_state});
        for (i = 0; i < 4; i++) begin
            enter(2'(i));
            leave();
        end
        enter(2'h3);
        host.put(1'b0, 8'hE2);
        idle(2);
        chk("sleep", 8'h01, {7'h00, sleep_mode});
        chk("standby", 8'h00, {7'h00, standby_mode});
        chk("volume", {2'h0, lpi_pkg::VOLUME_RESET}, {2'h0, volume_level});
        chk("ratio", {5'h00, lpi_pkg::RATIO_RESET}, {5'h00, regulator_resistor_ratio});
        chk("indicator", {6'h00, lpi_pkg::IND_RESET}, {6'h00, indicator_state});
        leave();
        host.put(1'b0, 8'hF5);
        host.put(1'b0, 8'hE0);
        host.put(1'b0, 8'hE3);
        chk("test", 8'h00, {7'h00, test_mode});
        chk("rmw", 8'h01, {7'h00, rmw_mode});
        host.put(1'b0, 8'hF0);
        chk("test", 8'h01, {7'h00, test_mode});
        host.put(1'b0, 8'hE2);
        chk("rmw_test", 8'h00, {6'h00, rmw_mode, test_mode});
        host.put(1'b0, 8'h25);
        chk("ratio", 8'h05, {5'h00, regulator_resistor_ratio});
        hw_reset_pin_n = 1'b0;
        idle(4);
        hw_reset_pin_n = 1'b1;
        idle(4);
        chk("ratio", 8'h00, {5'h00, regulator_resistor_ratio});
        host.put(1'b0, 8'h22);
        chk("ratio", 8'h02, {5'h00, regulator_resistor_ratio});
        close_out();
    end
endmodule : test_lpi_cmd
